// ===== hdl/apfs_port_regs.sv
// port format / de-emphasis register and converter status report
`timescale 1ns/1ns
module apfs_port_regs
  import apfs_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  awvalid,
  output      logic                  awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output      logic                  wready,
  output      logic [1:0]            bresp,
  output      logic                  bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic [2:0]            arprot,
  input  wire logic                  arvalid,
  output      logic                  arready,
  output      logic [31:0]           rdata,
  output      logic [1:0]            rresp,
  output      logic                  rvalid,
  input  wire logic                  rready,
  input  wire logic [PEAK_W-1:0]     peakSampleLeft,
  input  wire logic [PEAK_W-1:0]     peakSampleRight,
  input  wire logic                  volumeAcceptLeft,
  input  wire logic                  volumeAcceptRight,
  input  wire logic [1:0]            deemphPins,
  output      logic [1:0]            deemphCurve,
  output      logic                  bitClockEdgeSelect,
  output      logic                  outputWordFormat,
  output      logic [2:0]            inputWordFormat,
  output      logic                  irq
);

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  logic [5:0] wrIndex;
  logic [7:0] wrByte;
  logic       awHeld;
  logic       wHeld;
  logic       wrLane;
  logic       doWrite;
  logic [7:0] portMode;

  // address and data are taken in either order, one write at a time
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      awready <= 1'b1;
      awHeld  <= 1'b0;
      wrIndex <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      awHeld  <= 1'b1;
      wrIndex <= apfs_index(awaddr);
    end else if (doWrite) begin
      awHeld  <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wready <= 1'b1;
      wHeld  <= 1'b0;
      wrByte <= '0;
      wrLane <= 1'b0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wHeld  <= 1'b1;
      wrByte <= wdata[7:0];
      wrLane <= wstrb[0];
    end else if (doWrite) begin
      wHeld  <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  assign doWrite = awHeld && wHeld && !bvalid;

  logic wrMapped;
  logic wrPort;
  logic wrClear;
  logic wrEnable;

  always_comb begin
    wrPort   = 1'b0;
    wrClear  = 1'b0;
    wrEnable = 1'b0;
    wrMapped = 1'b1;
    if (wrIndex == IDX_PORT_MODE) begin
      wrPort = doWrite && wrLane;
    end else if (wrIndex == IDX_IRQ_CLEAR) begin
      wrClear = doWrite && wrLane;
    end else if (wrIndex == IDX_IRQ_ENABLE) begin
      wrEnable = doWrite && wrLane;
    end else if (wrIndex == IDX_REPORT ||
                 wrIndex == IDX_IRQ_STATUS) begin
      wrMapped = 1'b1;
    end else begin
      wrMapped = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // port mode register and its decoded outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      portMode <= PORT_RESET;
    end else if (wrPort) begin
      portMode <= wrByte;
    end
  end

  logic [2:0] deemphSelect;
  logic [1:0] next_deemphCurve;
  assign deemphSelect = portMode[DEEMPH_MSB:DEEMPH_LSB];

  // unused codes 5-7 are treated like the disable code
  always_comb begin
    if (deemphSelect == DEEMPH_BY_PINS) begin
      next_deemphCurve = deemphPins;
    end else if (deemphSelect == DEEMPH_44K1) begin
      next_deemphCurve = CURVE_44K1;
    end else if (deemphSelect == DEEMPH_48K) begin
      next_deemphCurve = CURVE_48K;
    end else if (deemphSelect == DEEMPH_32K) begin
      next_deemphCurve = CURVE_32K;
    end else begin
      next_deemphCurve = CURVE_OFF;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      deemphCurve        <= CURVE_OFF;
      bitClockEdgeSelect <= 1'b0;
      outputWordFormat   <= 1'b0;
      inputWordFormat    <= '0;
    end else begin
      deemphCurve        <= next_deemphCurve;
      bitClockEdgeSelect <= portMode[EDGE_BIT];
      outputWordFormat   <= portMode[OUTFMT_BIT];
      inputWordFormat    <= portMode[INFMT_MSB:INFMT_LSB];
    end
  end

  // ----------------------------------------------------------------
  // converter status: peaks, accept flags, events
  // ----------------------------------------------------------------
  logic              readTaken;
  logic              clearPeaks;
  logic [PEAK_W-1:0] peakLeft;
  logic [PEAK_W-1:0] peakRight;
  logic              roseLeft;
  logic              roseRight;
  logic [1:0]        accept;
  logic [1:0]        acceptSeen;

  assign readTaken  = arvalid && arready;
  assign clearPeaks = readTaken &&
                      (apfs_index(araddr) == IDX_PORT_MODE);

  apfs_peak_hold #(.W(PEAK_W)) u_peak_left (
    .core_clk (core_clk),
    .nrst     (nrst),
    .sample   (peakSampleLeft),
    .clear    (clearPeaks),
    .peak     (peakLeft),
    .rose     (roseLeft)
  );

  apfs_peak_hold #(.W(PEAK_W)) u_peak_right (
    .core_clk (core_clk),
    .nrst     (nrst),
    .sample   (peakSampleRight),
    .clear    (clearPeaks),
    .peak     (peakRight),
    .rose     (roseRight)
  );

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      accept     <= '0;
      acceptSeen <= '0;
    end else begin
      accept     <= {volumeAcceptRight, volumeAcceptLeft};
      acceptSeen <= accept;
    end
  end

  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqEnable;

  always_comb begin
    events             = '0;
    events[IRQ_PEAK_L] = roseLeft;
    events[IRQ_PEAK_R] = roseRight;
    events[IRQ_ACCEPT] = |(accept & ~acceptSeen);
  end

  apfs_irq_regs #(.N(IRQ_W)) u_irq (
    .core_clk (core_clk),
    .nrst     (nrst),
    .events   (events),
    .clearWe  (wrClear),
    .enableWe (wrEnable),
    .wrData   (wrByte[IRQ_W-1:0]),
    .status   (irqStatus),
    .enable   (irqEnable),
    .irq      (irq)
  );

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic [7:0] rdByte;
  logic       rdMapped;
  logic [5:0] rdIndex;

  assign rdIndex = apfs_index(araddr);

  // a port mode read clears the peaks; its read data holds the port mode, not the peaks
  always_comb begin
    rdByte   = '0;
    rdMapped = 1'b1;
    if (rdIndex == IDX_PORT_MODE) begin
      rdByte = portMode;
    end else if (rdIndex == IDX_REPORT) begin
      rdByte[ACC_R_BIT] = accept[1];
      rdByte[ACC_L_BIT] = accept[0];
      rdByte[PEAK_R_LSB +: PEAK_W] = peakRight;
      rdByte[PEAK_L_LSB +: PEAK_W] = peakLeft;
    end else if (rdIndex == IDX_IRQ_STATUS) begin
      rdByte[IRQ_W-1:0] = irqStatus;
    end else if (rdIndex == IDX_IRQ_ENABLE) begin
      rdByte[IRQ_W-1:0] = irqEnable;
    end else if (rdIndex == IDX_IRQ_CLEAR) begin
      rdByte = '0;
    end else begin
      rdMapped = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (readTaken) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h000000, rdByte};
      rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_mode_reset: assert property (
    @(posedge core_clk) disable iff (1'b0)
    !nrst |=> (portMode == PORT_RESET) && (deemphCurve == CURVE_OFF))
    else $error("port mode not zero after reset");
  chk_deemph_pins: assert property (
    deemphSelect == DEEMPH_BY_PINS |=> deemphCurve == $past(deemphPins))
    else $error("pin-controlled de-emphasis not followed");
  chk_deemph_rate: assert property (
    (deemphSelect != DEEMPH_BY_PINS && deemphSelect < DEEMPH_OFF)
    |=> deemphCurve == $past(deemphSelect[1:0]))
    else $error("forced de-emphasis rate wrong");
  chk_deemph_off: assert property (
    deemphSelect >= DEEMPH_OFF |=> deemphCurve == CURVE_OFF)
    else $error("de-emphasis not disabled");
  chk_edge_select: assert property (
    wrPort |=> ##1 bitClockEdgeSelect == $past(wrByte[EDGE_BIT], 2))
    else $error("bit clock edge select not applied");
  chk_word_formats: assert property (
    wrPort |=> ##1 (outputWordFormat == $past(wrByte[OUTFMT_BIT], 2)) &&
    (inputWordFormat == $past(wrByte[INFMT_MSB:INFMT_LSB], 2)))
    else $error("word format select not applied");
  chk_peak_clear: assert property (
    clearPeaks |=> (peakLeft == $past(peakSampleLeft)) &&
    (peakRight == $past(peakSampleRight)))
    else $error("peaks not cleared by register 5 read");
  chk_peak_sticky: assert property (
    !clearPeaks |=> (peakLeft >= $past(peakLeft)) &&
    (peakLeft >= $past(peakSampleLeft)))
    else $error("left peak dropped without a clear");
  chk_report_ro: assert property (
    (doWrite && wrIndex == IDX_REPORT && !clearPeaks)
    |=> $stable(portMode) && (peakRight >= $past(peakRight)))
    else $error("write to status report changed state");
  chk_write_answer: assert property (
    doWrite |=> bvalid [*1] ##0 !awready)
    else $error("write not answered");
  cov_port_write: cover property (wrPort ##2 bitClockEdgeSelect);
  cov_peak_clear: cover property ((peakLeft != '0) ##1 clearPeaks);
  cov_irq_fires: cover property (!irq ##1 irq);
  cov_unmapped: cover property (rvalid && rresp == RESP_SLVERR);

endmodule

// ===== hdl/apfs_pkg.sv
// constants shared by the audio port format and status register block
package apfs_pkg;

  // ----------------------------------------------------------------
  // bus and register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam int         AXI_ADDR_W     = 8;
  localparam logic [5:0] IDX_PORT_MODE  = 6'h05;
  localparam logic [5:0] IDX_REPORT     = 6'h06;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h08;
  localparam logic [5:0] IDX_IRQ_CLEAR  = 6'h09;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0A;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // port mode register layout
  // ----------------------------------------------------------------
  localparam int         DEEMPH_MSB  = 7;
  localparam int         DEEMPH_LSB  = 5;
  localparam int         EDGE_BIT    = 4;
  localparam int         OUTFMT_BIT  = 3;
  localparam int         INFMT_MSB   = 2;
  localparam int         INFMT_LSB   = 0;
  localparam logic [7:0] PORT_RESET  = 8'h00;

  localparam logic [2:0] DEEMPH_BY_PINS = 3'h0;
  localparam logic [2:0] DEEMPH_44K1    = 3'h1;
  localparam logic [2:0] DEEMPH_48K     = 3'h2;
  localparam logic [2:0] DEEMPH_32K     = 3'h3;
  localparam logic [2:0] DEEMPH_OFF     = 3'h4;

  // applied curve code, also the encoding of the selection pins
  localparam logic [1:0] CURVE_OFF  = 2'h0;
  localparam logic [1:0] CURVE_44K1 = 2'h1;
  localparam logic [1:0] CURVE_48K  = 2'h2;
  localparam logic [1:0] CURVE_32K  = 2'h3;

  // ----------------------------------------------------------------
  // status report and interrupt layout
  // ----------------------------------------------------------------
  localparam int PEAK_W      = 3;
  localparam int ACC_R_BIT   = 7;
  localparam int ACC_L_BIT   = 6;
  localparam int PEAK_R_LSB  = 3;
  localparam int PEAK_L_LSB  = 0;
  localparam int IRQ_PEAK_L  = 0;
  localparam int IRQ_PEAK_R  = 1;
  localparam int IRQ_ACCEPT  = 2;
  localparam int IRQ_W       = 3;

  function automatic logic [5:0] apfs_index(
    input logic [AXI_ADDR_W-1:0] addr
  );
    return addr[7:2];
  endfunction

endpackage

// ===== hdl/apfs_peak_hold.sv
// sticky peak level of one converter channel
`timescale 1ns/1ns
module apfs_peak_hold #(
  parameter int W = 3
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] sample,
  input  wire logic         clear,
  output      logic [W-1:0] peak,
  output      logic         rose
);

  function automatic logic [W-1:0] larger(
    input logic [W-1:0] a,
    input logic [W-1:0] b
  );
    return (a > b) ? a : b;
  endfunction

  // a sample in the clearing cycle is kept, so no peak is lost
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      peak <= '0;
    end else if (clear) begin
      peak <= sample;
    end else begin
      peak <= larger(peak, sample);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rose <= 1'b0;
    end else begin
      rose <= (sample > (clear ? {W{1'b0}} : peak));
    end
  end

endmodule

// ===== hdl/apfs_irq_regs.sv
// sticky event status, enable mask and level interrupt
`timescale 1ns/1ns
module apfs_irq_regs #(
  parameter int N = 3
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [N-1:0] events,
  input  wire logic         clearWe,
  input  wire logic         enableWe,
  input  wire logic [N-1:0] wrData,
  output      logic [N-1:0] status,
  output      logic [N-1:0] enable,
  output      logic         irq
);

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      status <= (status & ~(clearWe ? wrData : {N{1'b0}})) | events;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      enable <= '0;
    end else if (enableWe) begin
      enable <= wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & enable);
    end
  end

endmodule

// ===== test/apfs_host_model.sv
// host controller model issuing single register bus transfers
`timescale 1ns/1ns
module apfs_host_model
  import apfs_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  reqValid,
  input  wire logic                  reqWrite,
  input  wire logic [AXI_ADDR_W-1:0] reqAddr,
  input  wire logic [31:0]           reqData,
  output      logic                  reqDone,
  output      logic [31:0]           rspData,
  output      logic [1:0]            rspResp,
  output      logic [AXI_ADDR_W-1:0] awaddr,
  output      logic [2:0]            awprot,
  output      logic                  awvalid,
  input  wire logic                  awready,
  output      logic [31:0]           wdata,
  output      logic [3:0]            wstrb,
  output      logic                  wvalid,
  input  wire logic                  wready,
  input  wire logic [1:0]            bresp,
  input  wire logic                  bvalid,
  output      logic                  bready,
  output      logic [AXI_ADDR_W-1:0] araddr,
  output      logic [2:0]            arprot,
  output      logic                  arvalid,
  input  wire logic                  arready,
  input  wire logic [31:0]           rdata,
  input  wire logic [1:0]            rresp,
  input  wire logic                  rvalid,
  output      logic                  rready
);
  logic busy;

  assign awprot = 3'h0;
  assign arprot = 3'h0;

  // released payload is inverted so stale values never look valid
  always_ff @(posedge core_clk) begin
    reqDone <= 1'b0;
    if (!nrst) begin
      busy    <= 1'b0;
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      arvalid <= 1'b0;
      bready  <= 1'b0;
      rready  <= 1'b0;
      awaddr  <= 8'h00;
      araddr  <= 8'h00;
      wdata   <= 32'h0;
      wstrb   <= 4'h0;
      rspData <= 32'h0;
      rspResp <= 2'h0;
    end else if (busy) begin
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~awaddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~wdata;
      end
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~araddr;
      end
      if (bready && bvalid) begin
        bready  <= 1'b0;
        rspResp <= bresp;
        busy    <= 1'b0;
        reqDone <= 1'b1;
      end
      if (rready && rvalid) begin
        rready  <= 1'b0;
        rspData <= rdata;
        rspResp <= rresp;
        busy    <= 1'b0;
        reqDone <= 1'b1;
      end
    end else if (reqValid && !reqDone) begin
      // selector codes 5-7 are never requested by this host
      busy <= 1'b1;
      if (reqWrite) begin
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        awaddr  <= reqAddr;
        wdata   <= reqData;
        wstrb   <= 4'hF;
      end else begin
        arvalid <= 1'b1;
        rready  <= 1'b1;
        araddr  <= reqAddr;
      end
    end
  end
endmodule

// ===== test/audio_port_format_status_regs_tb.sv
// self-checking bench for the port format and status register block
`timescale 1ns/1ns
module audio_port_format_status_regs_tb
  import apfs_pkg::*;
;
  typedef struct packed {
    logic [7:0] data;
    logic [1:0] pins;
    logic [1:0] curve;
    logic       edgeSel;
    logic       ofmt;
    logic [2:0] ifmt;
  } apfs_row_t;

  logic core_clk, nrst, reqValid, reqWrite, reqDone;
  logic [7:0] reqAddr, awaddr, araddr;
  logic [31:0] reqData, rspData, wdata, rdata;
  logic [1:0] rspResp, bresp, rresp, deemphPins, deemphCurve;
  logic [2:0] awprot, arprot, peakSampleLeft, peakSampleRight;
  logic [2:0] inputWordFormat;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic volumeAcceptLeft, volumeAcceptRight;
  logic bitClockEdgeSelect, outputWordFormat;
  int error_cnt, checks;

  apfs_row_t rows [10] = '{
    '{8'h00, 2'h2, 2'h2, 1'b0, 1'b0, 3'h0},
    '{8'h00, 2'h3, 2'h3, 1'b0, 1'b0, 3'h0},
    '{8'h20, 2'h2, 2'h1, 1'b0, 1'b0, 3'h0},
    '{8'h40, 2'h0, 2'h2, 1'b0, 1'b0, 3'h0},
    '{8'h60, 2'h1, 2'h3, 1'b0, 1'b0, 3'h0},
    '{8'h80, 2'h3, 2'h0, 1'b0, 1'b0, 3'h0},
    '{8'h11, 2'h0, 2'h0, 1'b1, 1'b0, 3'h1},
    '{8'h0A, 2'h0, 2'h0, 1'b0, 1'b1, 3'h2},
    '{8'h03, 2'h0, 2'h0, 1'b0, 1'b0, 3'h3},
    '{8'h04, 2'h1, 2'h1, 1'b0, 1'b0, 3'h4}
  };

  apfs_port_regs i_apfs_port_regs (.*);
  apfs_host_model i_apfs_host_model (.*);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %08X expected %08X", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr  <= a;
    reqData  <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (reqDone !== 1'b1 && n < 100);
    reqValid <= 1'b0;
    if (reqDone !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 8'h00;
    reqData = 32'h0;
    peakSampleLeft = 3'h0;
    peakSampleRight = 3'h0;
    volumeAcceptLeft = 1'b0;
    volumeAcceptRight = 1'b0;
    deemphPins = 2'h0;
    error_cnt = 0;
    checks = 0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      deemphPins <= rows[i].pins;
      xfer(1'b1, 8'h14, {24'h0, rows[i].data});
      idle(2);
      check({30'h0, deemphCurve}, {30'h0, rows[i].curve});
      check({31'h0, bitClockEdgeSelect}, {31'h0, rows[i].edgeSel});
      check({28'h0, outputWordFormat, inputWordFormat},
            {28'h0, rows[i].ofmt, rows[i].ifmt});
      xfer(1'b0, 8'h14, 32'h0);
      check(rspData, {24'h0, rows[i].data});
    end
    $display("table test done");

    // sticky peaks hold the maximum, port mode read clears them
    peakSampleLeft <= 3'h5;
    peakSampleRight <= 3'h3;
    volumeAcceptLeft <= 1'b1;
    volumeAcceptRight <= 1'b1;
    idle(3);
    peakSampleLeft <= 3'h1;
    peakSampleRight <= 3'h2;
    idle(3);
    xfer(1'b0, 8'h18, 32'h0);
    check(rspData, 32'hDD);
    xfer(1'b0, 8'h14, 32'h0);
    xfer(1'b0, 8'h18, 32'h0);
    check(rspData, 32'hD1);
    xfer(1'b1, 8'h18, 32'hFF);
    check({30'h0, rspResp}, {30'h0, RESP_OKAY});
    xfer(1'b0, 8'h18, 32'h0);
    check(rspData, 32'hD1);
    $display("peak test done");

    // events latch while masked, then drive the level output
    xfer(1'b0, 8'h20, 32'h0);
    check(rspData, 32'h7);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, 8'h28, 32'h7);
    idle(3);
    check({31'h0, irq}, 32'h1);
    xfer(1'b1, 8'h24, 32'h3);
    idle(3);
    check({31'h0, irq}, 32'h1);
    xfer(1'b0, 8'h20, 32'h0);
    check(rspData, 32'h4);
    xfer(1'b1, 8'h28, 32'h3);
    idle(3);
    check({31'h0, irq}, 32'h0);
    xfer(1'b0, 8'h28, 32'h0);
    check(rspData, 32'h3);
    xfer(1'b1, 8'h24, 32'h4);
    xfer(1'b0, 8'h20, 32'h0);
    check(rspData, 32'h0);
    xfer(1'b0, 8'h24, 32'h0);
    check(rspData, 32'h0);
    $display("interrupt test done");

    // unmapped word answers with an error and no data
    xfer(1'b0, 8'h3C, 32'h0);
    check({30'h0, rspResp}, {30'h0, RESP_SLVERR});
    check(rspData, 32'h0);
    xfer(1'b1, 8'h3C, 32'h5A);
    check({30'h0, rspResp}, {30'h0, RESP_SLVERR});
    $display("unmapped test done");

    // mid-run reset returns the port mode register to zero
    deemphPins <= 2'h0;
    xfer(1'b1, 8'h14, 32'h9F);
    nrst <= 1'b0;
    idle(3);
    nrst <= 1'b1;
    idle(1);
    check({25'h0, deemphCurve, bitClockEdgeSelect, outputWordFormat,
           inputWordFormat}, 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    check(rspData, {24'h0, PORT_RESET});
    $display("reset test done");
    complete_run();
  end
endmodule
